// ### include/sadc_pkg.sv
package sadc_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int WORD_W     = 16;
  localparam int RES_W      = 12;
  localparam int CHAN_W     = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
  localparam int NOTAG_PAD  = 3;

  // ---------------------------------------------------------------
  // serial command word fields
  // ---------------------------------------------------------------
  localparam int         CMD_SEL_BIT     = 15;
  localparam int         CMD_CHAN_HI     = 14;
  localparam int         CMD_CHAN_LO     = 11;
  localparam int         CMD_RST_HI      = 4;
  localparam int         CMD_RST_LO      = 3;
  localparam int         CMD_SOFTWARE_CONVERT_BIT   = 1;
  localparam logic [1:0] SOFT_RESET_CODE = 2'h2;

  // ---------------------------------------------------------------
  // resolution variants and result masks
  // ---------------------------------------------------------------
  localparam logic [1:0]       RES_12   = 2'h0;
  localparam logic [1:0]       RES_10   = 2'h1;
  localparam logic [1:0]       RES_8    = 2'h2;
  localparam logic [RES_W-1:0] MASK_12  = 12'hfff;
  localparam logic [RES_W-1:0] MASK_10  = 12'hffc;
  localparam logic [RES_W-1:0] MASK_8   = 12'hff0;
  localparam logic [RES_W-1:0] UNI_MAX  = 12'hfff;
  localparam logic [RES_W-1:0] BIP_MAX  = 12'h7ff;
  localparam logic [RES_W-1:0] BIP_MIN  = 12'h800;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ     = 20_000_000;
  localparam int OSC_HZ         = 13_330_000;
  localparam int WAKE_OSC_TICKS = 16;
  localparam int ACQ_OSC_TICKS  = 4;
  localparam int SHUT_OSC_TICKS = 2;
  localparam int SW_DELAY_NS    = 1000;
  localparam int SYS_PERIOD_NS  = 50;
  localparam int WAKE_CYC = (WAKE_OSC_TICKS * (SYS_CLK_HZ / 1000) + OSC_HZ / 1000 - 1)
                            / (OSC_HZ / 1000);
  localparam int ACQ_CYC  = (ACQ_OSC_TICKS * (SYS_CLK_HZ / 1000) + OSC_HZ / 1000 - 1)
                            / (OSC_HZ / 1000);
  localparam int SHUT_CYC = (SHUT_OSC_TICKS * (SYS_CLK_HZ / 1000) + OSC_HZ / 1000 - 1)
                            / (OSC_HZ / 1000);
  localparam int SWDLY_CYC = (SW_DELAY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  typedef enum logic [2:0] {SC_IDLE, SC_SWDLY, SC_WAKE, SC_ACQ, SC_CONV, SC_SHUT} sadc_scan_e;
endpackage : sadc_pkg

// ### design/sadc_sync.sv
`timescale 1ns/10ps
module sadc_sync #(
  parameter logic INIT = 1'b1
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // level
  input  wire logic asyncIn,
  output logic      levelOut
);
  logic s1_r, s2_r, s3_r, level_r;
  logic levelNxt;

  always_comb begin
    levelNxt = (s2_r == s3_r) ? s3_r : level_r;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_r    <= INIT;
      s2_r    <= INIT;
      s3_r    <= INIT;
      level_r <= INIT;
    end else begin
      s1_r    <= asyncIn;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= levelNxt;
    end
  end

  assign levelOut = level_r;
endmodule : sadc_sync

// ### design/sadc_fifo.sv
`timescale 1ns/10ps
module sadc_fifo
  import sadc_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // control
  input  wire logic              flush,
  input  wire logic              push,
  input  wire logic [WORD_W-1:0] pushData,
  input  wire logic              pop,
  // status
  output logic [WORD_W-1:0]      headData,
  output logic                   empty,
  output logic                   full,
  output logic [FIFO_AW:0]       count
);
  logic [WORD_W-1:0]  mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] rd_r, wr_r, rdNxt, wrNxt;
  logic [FIFO_AW:0]   cnt_r, cntNxt;
  logic               popEff, dropOld;

  assign empty    = (cnt_r == '0);
  assign full     = (cnt_r == (FIFO_AW+1)'(FIFO_DEPTH));
  assign count    = cnt_r;
  assign headData = mem[rd_r];

  // ---------------------------------------------------------------
  // pointers, oldest entry dropped when full
  // ---------------------------------------------------------------
  always_comb begin
    popEff  = pop & ~empty;
    dropOld = push & full & ~popEff;
    rdNxt   = rd_r + FIFO_AW'(popEff | dropOld);
    wrNxt   = wr_r + FIFO_AW'(push);
    cntNxt  = cnt_r + (FIFO_AW+1)'(push & ~dropOld) - (FIFO_AW+1)'(popEff);
    if (flush) begin
      rdNxt  = '0;
      wrNxt  = '0;
      cntNxt = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_r  <= '0;
      wr_r  <= '0;
      cnt_r <= '0;
    end else begin
      rd_r  <= rdNxt;
      wr_r  <= wrNxt;
      cnt_r <= cntNxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push && !flush) begin
      mem[wr_r] <= pushData;
    end
  end

  a_fifo_overwrite: assert property (@(posedge sys_clk) disable iff (rst)
    (full && push && !pop && !flush) |=> (full && rd_r == $past(rd_r) + 4'h1))
    else $error("full fifo did not drop its oldest entry");

  a_fifo_grow: assert property (@(posedge sys_clk) disable iff (rst)
    (!full && push && !pop && !flush) |=> (cnt_r == $past(cnt_r) + 5'h01))
    else $error("fifo count did not grow on push");
endmodule : sadc_fifo

// ### design/sadc_top.sv
`timescale 1ns/10ps
// What this block does
// - with chip select low, capture serial input on each rising serial clock
// - change serial output on each falling serial clock edge
// - chip select falling edge samples the inputs and starts a frame
// - tag on: four channel bits then 12-bit result, msb first
// - tag off, external only: one zero, result, three trailing zeros
// - 10-bit variant zeroes two lsbs, 8-bit variant zeroes four
// - unipolar code is zero when positive input is below negative
// - unipolar straight binary, bipolar two's complement
// - pseudo-differential bits reference fifteen inputs to common; single-ended is unipolar
// - fifo holds sixteen results, overwrites oldest when full
// - each fifo entry is two bytes, channel bits ahead of msb
// - after chip select falls, oldest fifo data goes out; zeros when empty
// - external clock: channel from input each frame, converted in next frame, result in the frame after
// - internal clock: wake, acquire, convert, shut down automatically into fifo
// - start pulse low with chip select high runs one full scan
// - end of conversion low after scan until chip select or start falls
// - software convert starts after delay from chip select rise, self-clears
// - serial output floats while chip select is high
module sadc_top
  import sadc_pkg::*;
(
  // clocks and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                sclk,
  // serial port
  input  wire logic                csN,
  input  wire logic                din,
  output logic                     dout,
  output logic                     doutOe,
  // conversion start and end
  input  wire logic                conversionStartN,
  output logic                     eocN,
  // configuration
  input  wire logic                internalClockMode,
  input  wire logic                channelTagEnable,
  input  wire logic                pseudoDiffCommon,
  input  wire logic                diffModeEnable,
  input  wire logic                bipolarEnable,
  input  wire logic [1:0]          resolutionSel,
  input  wire logic [CHAN_W-1:0]   scanLastChannel,
  // status
  output logic                     softwareConvert,
  output logic [FIFO_AW:0]         fifoCount,
  // converter core
  output logic                     sampleHold,
  output logic                     convStart,
  output logic [CHAN_W-1:0]        convChannel,
  output logic                     commonInputRef,
  input  wire logic                convDone,
  input  wire logic signed [12:0]  convDiff
);
  // ---------------------------------------------------------------
  // link domain
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] shiftIn_r, shiftInNxt;
  logic [4:0]        bitIdx_r, bitIdxNxt;
  logic              dout_r, doutNxt;
  logic [WORD_W-1:0] outWord_r, outWordNxt;
  logic              linkRst;

  assign linkRst = rst | csN;

  always_comb begin
    shiftInNxt = {shiftIn_r[WORD_W-2:0], din};
    bitIdxNxt  = (bitIdx_r[4]) ? bitIdx_r : bitIdx_r + 5'h01;
    doutNxt    = (bitIdx_r[4]) ? 1'b0 : outWord_r[4'hf - bitIdx_r[3:0]];
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      shiftIn_r <= '0;
    end else if (!csN) begin
      shiftIn_r <= shiftInNxt;
    end
  end

  always_ff @(negedge sclk or posedge linkRst) begin
    if (linkRst) begin
      bitIdx_r <= '0;
      dout_r   <= 1'b0;
    end else begin
      bitIdx_r <= bitIdxNxt;
      dout_r   <= doutNxt;
    end
  end

  assign dout   = dout_r;
  assign doutOe = ~csN;

  a_din_capture: assert property (@(posedge sclk) disable iff (rst)
    !csN |=> (shiftIn_r[0] == $past(din)))
    else $error("serial input bit not captured");

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic csLvl, cnvLvl, csPrev_r, cnvPrev_r;
  logic csFall, csRise, cnvFall;

  sadc_sync #(.INIT(1'b1)) u_cs_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (csN),
    .levelOut(csLvl)
  );

  sadc_sync #(.INIT(1'b1)) u_cnv_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (conversionStartN),
    .levelOut(cnvLvl)
  );

  assign csFall  = csPrev_r & ~csLvl;
  assign csRise  = ~csPrev_r & csLvl;
  assign cnvFall = cnvPrev_r & ~cnvLvl;

  // ---------------------------------------------------------------
  // result coding
  // ---------------------------------------------------------------
  logic             unipolarEff;
  logic [RES_W-1:0] rawCode, resMask, fmtCode;

  always_comb begin
    unipolarEff = ~diffModeEnable | pseudoDiffCommon | ~bipolarEnable;
    if (unipolarEff) begin
      if (convDiff < 0) begin
        rawCode = '0;
      end else if (convDiff > $signed({1'b0, UNI_MAX})) begin
        rawCode = UNI_MAX;
      end else begin
        rawCode = convDiff[RES_W-1:0];
      end
    end else begin
      if (convDiff > $signed({1'b0, BIP_MAX})) begin
        rawCode = BIP_MAX;
      end else if (convDiff < $signed({1'b1, BIP_MIN})) begin
        rawCode = BIP_MIN;
      end else begin
        rawCode = convDiff[RES_W-1:0];
      end
    end
    case (resolutionSel)
      RES_10:  resMask = MASK_10;
      RES_8:   resMask = MASK_8;
      default: resMask = MASK_12;
    endcase
    fmtCode = rawCode & resMask;
  end

  a_unipolar_floor: assert property (@(posedge sys_clk) disable iff (rst)
    (unipolarEff && convDiff < 0) |-> (fmtCode == '0))
    else $error("unipolar negative input gave nonzero code");

  a_res_mask: assert property (@(posedge sys_clk) disable iff (rst)
    (resolutionSel == RES_8) |-> (fmtCode[3:0] == 4'h0))
    else $error("8-bit variant low bits not zero");

  // ---------------------------------------------------------------
  // fifo
  // ---------------------------------------------------------------
  logic              fifoPush, fifoPop, fifoFlush, fifoEmpty;
  logic [WORD_W-1:0] fifoHead, fifoIn;

  sadc_fifo u_fifo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .flush   (fifoFlush),
    .push    (fifoPush),
    .pushData(fifoIn),
    .pop     (fifoPop),
    .headData(fifoHead),
    .empty   (fifoEmpty),
    .full    (),
    .count   (fifoCount)
  );

  // ---------------------------------------------------------------
  // frame control, scan sequencer and end of conversion
  // ---------------------------------------------------------------
  sadc_scan_e        scan_r, scanNxt;
  logic [7:0]        cnt_r, cntNxt;
  logic [CHAN_W-1:0] chan_r, chanNxt, chanNext_r, chanNextNxt;
  logic [WORD_W-1:0] extWord_r, extWordNxt;
  logic              eocN_r, eocNNxt, sw_r, swNxt;
  logic              start_r, startNxt, sample_r, sampleNxt;
  logic              softRst;

  assign softRst = csRise && !shiftIn_r[CMD_SEL_BIT]
                   && shiftIn_r[CMD_RST_HI:CMD_RST_LO] == SOFT_RESET_CODE;

  always_comb begin
    scanNxt     = scan_r;
    cntNxt      = (cnt_r == '0) ? cnt_r : cnt_r - 8'h01;
    chanNxt     = chan_r;
    chanNextNxt = chanNext_r;
    extWordNxt  = extWord_r;
    eocNNxt     = eocN_r;
    swNxt       = sw_r;
    startNxt    = 1'b0;
    sampleNxt   = csFall;
    fifoPush    = 1'b0;
    fifoPop     = csFall & internalClockMode & ~fifoEmpty;
    fifoFlush   = 1'b0;
    fifoIn      = {chan_r, fmtCode};
    outWordNxt  = outWord_r;
    if (csLvl) begin
      if (internalClockMode) begin
        outWordNxt = fifoEmpty ? '0 : fifoHead;
      end else begin
        outWordNxt = extWord_r;
      end
    end
    if (csFall || cnvFall) begin
      eocNNxt = 1'b1;
    end
    if (csFall && !internalClockMode) begin
      startNxt = 1'b1;
      chanNxt  = chanNext_r;
    end
    if (convDone && !internalClockMode) begin
      if (channelTagEnable) begin
        extWordNxt = {chan_r, fmtCode};
      end else begin
        extWordNxt = {1'b0, fmtCode, NOTAG_PAD'(0)};
      end
    end
    if (csRise && !shiftIn_r[CMD_SEL_BIT]) begin
      chanNextNxt = shiftIn_r[CMD_CHAN_HI:CMD_CHAN_LO];
    end
    case (scan_r)
      SC_IDLE: begin
        if (internalClockMode && csLvl && cnvFall) begin
          scanNxt = SC_WAKE;
          cntNxt  = 8'(WAKE_CYC);
          chanNxt = '0;
        end else if (internalClockMode && csRise && !shiftIn_r[CMD_SEL_BIT]
                     && shiftIn_r[CMD_SOFTWARE_CONVERT_BIT]) begin
          swNxt   = 1'b1;
          scanNxt = SC_SWDLY;
          cntNxt  = 8'(SWDLY_CYC);
          chanNxt = '0;
        end
      end
      SC_SWDLY: begin
        if (cnt_r == '0) begin
          scanNxt = SC_WAKE;
          cntNxt  = 8'(WAKE_CYC);
        end
      end
      SC_WAKE: begin
        if (cnt_r == '0) begin
          scanNxt = SC_ACQ;
          cntNxt  = 8'(ACQ_CYC);
        end
      end
      SC_ACQ: begin
        if (cnt_r == '0) begin
          scanNxt  = SC_CONV;
          startNxt = 1'b1;
        end
      end
      SC_CONV: begin
        if (convDone) begin
          fifoPush = 1'b1;
          if (chan_r == scanLastChannel) begin
            scanNxt = SC_SHUT;
            cntNxt  = 8'(SHUT_CYC);
          end else begin
            scanNxt = SC_ACQ;
            cntNxt  = 8'(ACQ_CYC);
            chanNxt = chan_r + 4'h1;
          end
        end
      end
      SC_SHUT: begin
        if (cnt_r == '0) begin
          scanNxt = SC_IDLE;
          eocNNxt = 1'b0;
          swNxt   = 1'b0;
        end
      end
      default: begin
        scanNxt = SC_IDLE;
      end
    endcase
    if (softRst) begin
      scanNxt    = SC_IDLE;
      fifoFlush  = 1'b1;
      swNxt      = 1'b0;
      eocNNxt    = 1'b1;
      extWordNxt = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      csPrev_r   <= 1'b1;
      cnvPrev_r  <= 1'b1;
      scan_r     <= SC_IDLE;
      cnt_r      <= '0;
      chan_r     <= '0;
      chanNext_r <= '0;
      extWord_r  <= '0;
      eocN_r     <= 1'b1;
      sw_r       <= 1'b0;
      start_r    <= 1'b0;
      sample_r   <= 1'b0;
      outWord_r  <= '0;
    end else begin
      csPrev_r   <= csLvl;
      cnvPrev_r  <= cnvLvl;
      scan_r     <= scanNxt;
      cnt_r      <= cntNxt;
      chan_r     <= chanNxt;
      chanNext_r <= chanNextNxt;
      extWord_r  <= extWordNxt;
      eocN_r     <= eocNNxt;
      sw_r       <= swNxt;
      start_r    <= startNxt;
      sample_r   <= sampleNxt;
      outWord_r  <= outWordNxt;
    end
  end

  assign eocN            = eocN_r;
  assign softwareConvert = sw_r;
  assign convStart       = start_r;
  assign convChannel     = chan_r;
  assign sampleHold      = sample_r;
  assign commonInputRef  = pseudoDiffCommon;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_eoc_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (!eocN_r && !csFall && !cnvFall && !softRst) |=> !eocN_r)
    else $error("end of conversion released too early");

  a_scan_end: assert property (@(posedge sys_clk) disable iff (rst)
    (scan_r == SC_SHUT && cnt_r == '0 && !softRst) |=> (!eocN_r && !sw_r && scan_r == SC_IDLE))
    else $error("scan end did not signal and self-clear");

  a_sample_frame: assert property (@(posedge sys_clk) disable iff (rst)
    csFall |=> sampleHold)
    else $error("frame start did not sample");

  a_ext_start: assert property (@(posedge sys_clk) disable iff (rst)
    (csFall && !internalClockMode) |=> (convStart && convChannel == $past(chanNext_r)))
    else $error("external conversion not started with frame channel");

  a_tag_word: assert property (@(posedge sys_clk) disable iff (rst)
    (convDone && !internalClockMode && channelTagEnable && !softRst)
    |=> (extWord_r == {$past(chan_r), $past(fmtCode)}))
    else $error("tagged word malformed");

  a_notag_word: assert property (@(posedge sys_clk) disable iff (rst)
    (convDone && !internalClockMode && !channelTagEnable && !softRst)
    |=> (extWord_r[15] == 1'b0 && extWord_r[2:0] == 3'h0))
    else $error("untagged word padding wrong");

  a_empty_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (csLvl && internalClockMode && fifoEmpty) |=> (outWord_r == '0))
    else $error("empty fifo did not present zeros");

  a_wake_time: assert property (@(posedge sys_clk) disable iff (rst)
    (scan_r == SC_IDLE && scanNxt == SC_WAKE)
    |=> (scan_r == SC_WAKE && cnt_r == 8'(WAKE_CYC)) ##1 (scan_r == SC_WAKE)[*8])
    else $error("wake step too short or mis-timed");
endmodule : sadc_top

// ### tb/sadc_host_model.sv
`timescale 1ns/10ps
module sadc_host_model (
  // serial port
  output logic     sclk,
  output logic     csN,
  output logic     din,
  input  wire logic dout,
  input  wire logic doutOe,
  // conversion start
  output logic     conversionStartN
);
  initial begin
    sclk = 1'b1;
    csN = 1'b1;
    din = 1'b0;
    conversionStartN = 1'b1;
  end

  // ---------------------------------------------------------------
  // one 16-bit frame, 64 ns clock that only runs inside the frame
  // ---------------------------------------------------------------
  task automatic frame(input logic [15:0] cmd, output logic [15:0] rsp);
    csN = 1'b0;
    #320;
    for (int k = 15; k >= 0; k--) begin
      sclk = 1'b0;
      din = cmd[k];
      #32;
      sclk = 1'b1;
      rsp[k] = doutOe ? dout : 1'bx;
      #32;
    end
    #64;
    csN = 1'b1;
    din = ~din;
    // clock held high well over a period before the next fall
    #400;
  endtask : frame

  task automatic start_pulse();
    conversionStartN = 1'b0;
    #200;
    conversionStartN = 1'b1;
  endtask : start_pulse
endmodule : sadc_host_model

// ### tb/tb_sadc_top.sv
`timescale 1ns/10ps
module tb_sadc_top import sadc_pkg::*; ;
  logic              sys_clk = 1'b0, rst = 1'b1, convDone = 1'b0;
  logic              internalClockMode = 1'b0, channelTagEnable = 1'b1;
  logic              pseudoDiffCommon = 1'b0, diffModeEnable = 1'b1, bipolarEnable = 1'b0;
  logic [1:0]        resolutionSel = 2'h0;
  logic [3:0]        scanLastChannel = 4'h0;
  logic signed [12:0] convDiff = 13'h0000;
  logic              sclk, csN, din, dout, doutOe, conversionStartN, eocN;
  logic              softwareConvert, sampleHold, convStart, commonInputRef;
  logic [3:0]        convChannel;
  logic [4:0]        fifoCount;
  logic [15:0]       fq[$];
  int                errors = 0, comparisons = 0, scanCh = 0, holds = 0;
  int                extD[$];

  sadc_top u_sadc_top (.sys_clk, .rst, .sclk, .csN, .din, .dout, .doutOe,
    .conversionStartN, .eocN, .internalClockMode, .channelTagEnable, .pseudoDiffCommon,
    .diffModeEnable, .bipolarEnable, .resolutionSel, .scanLastChannel, .softwareConvert,
    .fifoCount, .sampleHold, .convStart, .convChannel, .commonInputRef, .convDone,
    .convDiff);
  sadc_host_model u_sadc_host_model (.sclk, .csN, .din, .dout, .doutOe, .conversionStartN);

  always #25 sys_clk = ~sys_clk;

  // counts sample pulses, one per frame
  always @(posedge sys_clk) if (sampleHold === 1'b1) holds++;

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  function automatic logic [15:0] fmtw(input int ch, input int d);
    int c;
    if (pseudoDiffCommon || !diffModeEnable || !bipolarEnable)
      c = (d < 0) ? 0 : (d > 4095 ? 4095 : d);
    else
      c = (d > 2047) ? 2047 : (d < -2048 ? -2048 : d);
    c = c & (resolutionSel == 2'h1 ? 'hffc : resolutionSel == 2'h2 ? 'hff0 : 'hfff);
    return channelTagEnable ? {ch[3:0], c[11:0]} : {1'b0, c[11:0], 3'h0};
  endfunction : fmtw

  // converter core: answers three cycles after each start
  always @(posedge sys_clk) begin
    if (convStart === 1'b1) begin
      int d;
      d = int'($urandom_range(8190)) - 4095;
      if (internalClockMode) check("conv channel", 16'(scanCh), 16'(convChannel));
      repeat (3) @(posedge sys_clk);
      convDiff <= 13'(d);
      convDone <= 1'b1;
      @(posedge sys_clk);
      convDone <= 1'b0;
      if (internalClockMode) begin
        fq.push_back(fmtw(scanCh, d));
        scanCh++;
        if (fq.size() > FIFO_DEPTH) void'(fq.pop_front());
      end else extD.push_back(d);
    end
  end

  // ---------------------------------------------------------------
  // checking and sequencing
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  // internal mode read: pops the model, zero when empty
  task automatic rd(input logic [15:0] cmd);
    logic [15:0] rsp;
    logic [15:0] exp;
    int          h;
    exp = fq.size() > 0 ? fq.pop_front() : 16'h0000;
    h = holds;
    u_sadc_host_model.frame(cmd, rsp);
    check("fifo word", exp, rsp);
    check("sample hold", 16'(h + 1), 16'(holds));
    check("dout enable", 16'h0, 16'(doutOe));
  endtask : rd

  task automatic ext_seg(input int s);
    logic [15:0] rsp;
    int ch[$];
    @(posedge sys_clk);
    channelTagEnable <= s[0];
    bipolarEnable <= s[1];
    resolutionSel <= 2'(s % 3);
    pseudoDiffCommon <= (s == 5);
    diffModeEnable <= (s != 4);
    extD.delete();
    for (int i = 0; i < 6; i++) begin
      ch.push_back(int'($urandom_range(15)));
      u_sadc_host_model.frame({1'b0, 4'(ch[i]), 11'h000}, rsp);
      if (i >= 2) check("ext word", fmtw(ch[i-2], extD[i-1]), rsp);
    end
    check("common ref", 16'(pseudoDiffCommon), 16'(commonInputRef));
  endtask : ext_seg

  task automatic scan(input int last, input logic sw);
    int n;
    @(posedge sys_clk);
    scanLastChannel <= 4'(last);
    scanCh = 0;
    if (sw) begin
      rd(16'h0002);
      check("sw pending", 16'h1, 16'(softwareConvert));
    end else u_sadc_host_model.start_pulse();
    // a start pulse first releases the end-of-conversion flag of the previous scan
    for (n = 0; n < 40 && eocN !== 1'b1; n++) @(posedge sys_clk);
    if (!sw) check("eoc start clear", 16'h1, 16'(eocN));
    for (n = 0; n < 20000 && eocN !== 1'b0; n++) @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    check("eoc low", 16'h0, 16'(eocN));
    check("sw cleared", 16'h0, 16'(softwareConvert));
  endtask : scan

  initial begin
    #3000000;
    errors++;
    finish_test();
  end

  initial begin
    void'($urandom(8));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int s = 0; s < 6; s++) ext_seg(s);
    @(posedge sys_clk);
    internalClockMode <= 1'b1;
    channelTagEnable <= 1'b1;
    rd(16'h0010);
    fq.delete();
    scan(3, 1'b1);
    check("fifo count", 16'h4, 16'(fifoCount));
    rd(16'h0000);
    check("eoc cleared", 16'h1, 16'(eocN));
    repeat (4) rd(16'h0000);
    scan(15, 1'b0);
    scan(2, 1'b0);
    check("fifo full", 16'h10, 16'(fifoCount));
    repeat (3) rd(16'h0000);
    rd(16'h8010);
    check("bad reset", 16'hc, 16'(fifoCount));
    rd(16'h0010);
    fq.delete();
    check("soft reset", 16'h0, 16'(fifoCount));
    rd(16'h0000);
    @(posedge sys_clk);
    internalClockMode <= 1'b0;
    ext_seg(2);
    finish_test();
  end
endmodule : tb_sadc_top
